// file: core/flash_host_pkg.sv
// Constants, commands and carrier structs for the parallel flash host controller.
// Assumes a word-mode x16 flash and a 50 MHz system clock.
package flash_host_pkg;
	localparam int          CLK_MHZ         = 50;
	// Flash command codes and unlock addresses
	localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
	localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
	localparam logic [7:0]  CMD_SETUP       = 8'h80;
	localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
	localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
	localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
	localparam logic [7:0]  CMD_RESUME      = 8'h30;
	localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
	localparam logic [7:0]  CMD_RESET       = 8'hf0;
	localparam logic [15:0] ADDR_UNLOCK1    = 16'h0555;
	localparam logic [15:0] ADDR_UNLOCK2    = 16'h02aa;
	// Status bit positions of the flash data bus
	localparam int          BIT_POLL        = 7;
	localparam int          BIT_TOGGLE      = 6;
	localparam int          BIT_TIMEOUT     = 5;
	localparam int          BIT_WINDOW      = 3;
	localparam int          BIT_SECT_TOGGLE = 2;
	// Bus timing of one flash access, in cycles of sys_clk
	localparam int          T_ACCESS_NS     = 120;
	localparam logic [3:0]  ACCESS_CYC      = 4'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);
	// Sector-load window, 30 us; host stays well inside it
	localparam int          T_LOAD_US       = 30;
	localparam int          LOAD_CYC        = T_LOAD_US * CLK_MHZ;
	// Wishbone register offsets (bytes)
	localparam logic [3:0]  REG_CTRL        = 4'h0;
	localparam logic [3:0]  REG_ADDR        = 4'h4;
	localparam logic [3:0]  REG_DATA        = 4'h8;
	localparam logic [3:0]  REG_STAT        = 4'hc;
	// Operation codes written to REG_CTRL[3:0]
	localparam logic [3:0]  OP_READ         = 4'h1;
	localparam logic [3:0]  OP_PROGRAM      = 4'h2;
	localparam logic [3:0]  OP_CHIP_ERASE   = 4'h3;
	localparam logic [3:0]  OP_SECT_ERASE   = 4'h4;
	localparam logic [3:0]  OP_SECT_ADD     = 4'h5;
	localparam logic [3:0]  OP_SUSPEND      = 4'h6;
	localparam logic [3:0]  OP_RESUME       = 4'h7;
	localparam logic [3:0]  OP_RESET        = 4'h8;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [15:0] addr;
		logic [15:0] dout;
		logic        dq_oe_n;
	} flash_out_t;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic        fail;
		logic        ready_pin;
	} host_stat_t;
endpackage : flash_host_pkg

// file: core/flash_host.sv
// Host-side controller that issues command sequences to an asynchronous NOR flash
// and polls its status bits. Software drives it over classic Wishbone.
// Assumes flash dq and ready_busy pins are asynchronous to sys_clk.

module flash_host (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	output logic             flash_we_n,
	output logic      [15:0] flash_addr,
	output logic      [15:0] flash_dq_o,
	output logic             flash_dq_oe_n,
	input  wire logic [15:0] flash_dq_i,
	input  wire logic        ready_busy_output
);
	typedef enum {S_IDLE, S_WR, S_RD, S_NEXT, S_POLL} state_t;

	state_t                  state_r, state_nxt;
	flash_host_pkg::flash_out_t fo_r, fo_nxt;
	flash_host_pkg::host_stat_t st_r, st_nxt;
	logic [3:0]              op_r, op_nxt;
	logic [2:0]              step_r, step_nxt;
	logic [3:0]              cnt_r, cnt_nxt;
	logic [15:0]             adr_r, adr_nxt;
	logic [15:0]             dat_r, dat_nxt;
	logic [15:0]             rd_r, rd_nxt;
	logic                    have_prev_r, have_prev_nxt;
	logic [31:0]             wb_dat_nxt;
	logic                    ack_nxt;
	logic [15:0]             dq_s1, dq_s2, dq_s3;
	logic [2:0]              rb_s;

	// Command word for each write step of the current operation
	function automatic logic [31:0] seq_word(input logic [3:0] op, input logic [2:0] step,
		input logic [15:0] a, input logic [15:0] d);
		logic [7:0] code;
		code = (op == flash_host_pkg::OP_CHIP_ERASE) ? flash_host_pkg::CMD_CHIP_ERASE
			: flash_host_pkg::CMD_SECT_ERASE;
		case (step)
			3'd0: seq_word = {flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::CMD_UNLOCK1};
			3'd1: seq_word = {flash_host_pkg::ADDR_UNLOCK2, 8'h00, flash_host_pkg::CMD_UNLOCK2};
			3'd2: seq_word = (op == flash_host_pkg::OP_PROGRAM)
				? {flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::CMD_PROGRAM}
				: {flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::CMD_SETUP};
			3'd3: seq_word = (op == flash_host_pkg::OP_PROGRAM) ? {a, d}
				: {flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::CMD_UNLOCK1};
			3'd4: seq_word = {flash_host_pkg::ADDR_UNLOCK2, 8'h00, flash_host_pkg::CMD_UNLOCK2};
			default: seq_word = (op == flash_host_pkg::OP_CHIP_ERASE)
				? {flash_host_pkg::ADDR_UNLOCK1, 8'h00, code}
				: {a, 8'h00, code};
		endcase
	endfunction : seq_word

	// Index of the last write step in each operation, one below its number of writes
	function automatic logic [2:0] last_step(input logic [3:0] op);
		case (op)
			flash_host_pkg::OP_PROGRAM:    last_step = 3'd3;
			flash_host_pkg::OP_CHIP_ERASE: last_step = 3'd5;
			flash_host_pkg::OP_SECT_ERASE: last_step = 3'd5;
			default:                       last_step = 3'd0;
		endcase
	endfunction : last_step

	// Three-stage capture of asynchronous pins
	always_ff @(posedge sys_clk)
	begin
		dq_s1 <= flash_dq_i;
		dq_s2 <= dq_s1;
		dq_s3 <= dq_s2;
		rb_s  <= {rb_s[1:0], ready_busy_output};
	end

	// Flash sequencing and register file
	always_comb
	begin
		logic [31:0] w;
		logic        stable;
		w             = seq_word(op_r, step_r, adr_r, dat_r);
		stable        = (dq_s2 == dq_s3);
		state_nxt     = state_r;
		fo_nxt        = fo_r;
		st_nxt        = st_r;
		op_nxt        = op_r;
		step_nxt      = step_r;
		cnt_nxt       = cnt_r;
		adr_nxt       = adr_r;
		dat_nxt       = dat_r;
		rd_nxt        = rd_r;
		have_prev_nxt = have_prev_r;
		ack_nxt       = 1'b0;
		wb_dat_nxt    = wb_dat_o;
		if (rb_s[1] == rb_s[2])
			st_nxt.ready_pin = rb_s[2];
		if (wb_cyc_i && wb_stb_i && !wb_ack_o)
		begin
			ack_nxt = 1'b1;
			case (wb_adr_i)
				flash_host_pkg::REG_CTRL:
				begin
					wb_dat_nxt = {28'h0, op_r};
					if (wb_we_i && wb_sel_i[0] && state_r == S_IDLE)
					begin
						op_nxt         = wb_dat_i[3:0];
						step_nxt       = 3'd0;
						cnt_nxt        = 4'h0;
						st_nxt.busy    = 1'b1;
						st_nxt.done    = 1'b0;
						st_nxt.fail    = 1'b0;
						have_prev_nxt  = 1'b0;
						state_nxt      = (wb_dat_i[3:0] == flash_host_pkg::OP_READ) ? S_RD : S_WR;
					end
				end
				flash_host_pkg::REG_ADDR:
				begin
					wb_dat_nxt = {16'h0, adr_r};
					if (wb_we_i)
						adr_nxt = wb_dat_i[15:0];
				end
				flash_host_pkg::REG_DATA:
				begin
					wb_dat_nxt = {16'h0, rd_r};
					if (wb_we_i)
						dat_nxt = wb_dat_i[15:0];
				end
				flash_host_pkg::REG_STAT: wb_dat_nxt = {28'h0, st_r};
				default:                  wb_dat_nxt = 32'h0;
			endcase
		end
		case (state_r)
			S_IDLE:
			begin
				fo_nxt.ce_n    = 1'b1;
				fo_nxt.oe_n    = 1'b1;
				fo_nxt.we_n    = 1'b1;
				fo_nxt.dq_oe_n = 1'b1;
			end
			S_WR:
			begin
				// Single-write commands: the added sector, suspend, resume, reset
				case (op_r)
					flash_host_pkg::OP_SECT_ADD: w = {adr_r, 8'h00, flash_host_pkg::CMD_SECT_ERASE};
					flash_host_pkg::OP_SUSPEND:  w = {adr_r, 8'h00, flash_host_pkg::CMD_SUSPEND};
					flash_host_pkg::OP_RESUME:   w = {adr_r, 8'h00, flash_host_pkg::CMD_RESUME};
					flash_host_pkg::OP_RESET:    w = {adr_r, 8'h00, flash_host_pkg::CMD_RESET};
					default: ;
				endcase
				fo_nxt.ce_n    = 1'b0;
				fo_nxt.oe_n    = 1'b1;
				fo_nxt.addr    = w[31:16];
				fo_nxt.dout    = w[15:0];
				fo_nxt.dq_oe_n = 1'b0;
				// Address set before we_n falls, data held past its rise
				fo_nxt.we_n    = !(cnt_r != 4'h0 && cnt_r <= flash_host_pkg::ACCESS_CYC);
				cnt_nxt        = cnt_r + 4'h1;
				if (cnt_r == flash_host_pkg::ACCESS_CYC + 4'h1)
					state_nxt = S_NEXT;
			end
			S_NEXT:
			begin
				fo_nxt.ce_n    = 1'b1;
				cnt_nxt        = 4'h0;
				if (step_r < last_step(op_r))
				begin
					step_nxt  = step_r + 3'd1;
					state_nxt = S_WR;
				end
				else if (op_r == flash_host_pkg::OP_PROGRAM || op_r == flash_host_pkg::OP_CHIP_ERASE
					|| op_r == flash_host_pkg::OP_RESUME)
					state_nxt = S_POLL;
				else
				begin
					// Sector loads return at once so more may follow inside the window
					st_nxt.busy = 1'b0;
					st_nxt.done = 1'b1;
					state_nxt   = S_IDLE;
				end
			end
			S_RD, S_POLL:
			begin
				fo_nxt.ce_n    = 1'b0;
				fo_nxt.oe_n    = 1'b0;
				fo_nxt.we_n    = 1'b1;
				fo_nxt.dq_oe_n = 1'b1;
				fo_nxt.addr    = adr_r;
				cnt_nxt        = cnt_r + 4'h1;
				if (cnt_r == flash_host_pkg::ACCESS_CYC + 4'h3)
				begin
					rd_nxt        = dq_s3;
					fo_nxt.oe_n   = 1'b1;
					cnt_nxt       = 4'h0;
					have_prev_nxt = 1'b1;
					if (state_r == S_RD)
					begin
						st_nxt.busy = 1'b0;
						st_nxt.done = 1'b1;
						state_nxt   = S_IDLE;
					end
					// Two reads with a steady toggle bit mean the algorithm ended
					else if (have_prev_r && stable && rd_r[flash_host_pkg::BIT_TOGGLE]
						== dq_s3[flash_host_pkg::BIT_TOGGLE])
					begin
						st_nxt.busy = 1'b0;
						st_nxt.done = 1'b1;
						st_nxt.fail = (op_r == flash_host_pkg::OP_PROGRAM)
							&& (dq_s3[flash_host_pkg::BIT_POLL] != dat_r[flash_host_pkg::BIT_POLL]);
						state_nxt   = S_IDLE;
					end
					else if (dq_s3[flash_host_pkg::BIT_TIMEOUT] && have_prev_r
						&& rd_r[flash_host_pkg::BIT_TIMEOUT])
					begin
						// Still toggling with the timeout flag up: give up, software resets
						st_nxt.busy = 1'b0;
						st_nxt.fail = 1'b1;
						state_nxt   = S_IDLE;
					end
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_r     <= S_IDLE;
			fo_r        <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 16'h0, dout: 16'h0,
				dq_oe_n: 1'b1};
			st_r        <= '0;
			op_r        <= 4'h0;
			step_r      <= 3'd0;
			cnt_r       <= 4'h0;
			adr_r       <= 16'h0;
			dat_r       <= 16'h0;
			rd_r        <= 16'h0;
			have_prev_r <= 1'b0;
			wb_dat_o    <= 32'h0;
			wb_ack_o    <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			fo_r        <= fo_nxt;
			st_r        <= st_nxt;
			op_r        <= op_nxt;
			step_r      <= step_nxt;
			cnt_r       <= cnt_nxt;
			adr_r       <= adr_nxt;
			dat_r       <= dat_nxt;
			rd_r        <= rd_nxt;
			have_prev_r <= have_prev_nxt;
			wb_dat_o    <= wb_dat_nxt;
			wb_ack_o    <= ack_nxt;
		end
	end

	assign flash_ce_n    = fo_r.ce_n;
	assign flash_oe_n    = fo_r.oe_n;
	assign flash_we_n    = fo_r.we_n;
	assign flash_addr    = fo_r.addr;
	assign flash_dq_o    = fo_r.dout;
	assign flash_dq_oe_n = fo_r.dq_oe_n;
endmodule : flash_host

// file: sim/flash_host_monitor.sv
// Checker on the Wishbone handshake and the flash pins of the host.
// Assumes sys_clk is the only clock; bound to every flash_host.
module flash_host_monitor (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        flash_ce_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic [15:0] flash_addr,
	input wire logic [15:0] flash_dq_o,
	input wire logic        flash_dq_oe_n
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// Previous strobe level, last written address and command byte
	logic [24:0] hist_r;
	logic [24:0] hist_nxt;
	logic        wfall;
	assign wfall = hist_r[24] && !flash_we_n;
	always_comb
	begin
		hist_nxt = {flash_we_n, hist_r[23:0]};
		if (wfall)
			hist_nxt[23:0] = {flash_addr, flash_dq_o[7:0]};
	end
	always_ff @(posedge sys_clk)
		hist_r <= sys_rst ? {1'b1, 24'h0} : hist_nxt;
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	a_write_strobe: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
		else $error("write strobe outside a write cycle");
	a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*6] ##1 flash_we_n)
		else $error("write strobe width wrong");
	a_write_hold: assert property (!flash_we_n && $past(!flash_we_n) |->
		$stable(flash_addr) && $stable(flash_dq_o))
		else $error("address or data moved under strobe");
	a_setup_unlock: assert property (wfall && hist_r[23:0] == 24'h055580 |->
		flash_addr == 16'h0555 && flash_dq_o[7:0] == 8'haa)
		else $error("set-up code not followed by unlock");
	a_unlock_pair: assert property (wfall && hist_r[23:0] == 24'h0555aa |->
		flash_addr == 16'h02aa && flash_dq_o[7:0] == 8'h55)
		else $error("second unlock write wrong");
	a_read_hold: assert property (!flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr))
		else $error("address moved during a read");
	a_read_no_drive: assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
		else $error("host drives data during a read");
endmodule : flash_host_monitor

bind flash_host flash_host_monitor i_flash_host_monitor (.sys_clk, .sys_rst, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o,
	.flash_dq_oe_n);

// file: sim/flash_model.sv
// Behavioural flash: command sequencer, status reads and ready/busy.
// Assumes clk only paces the internal timers.
module flash_model #(
	parameter int PROG_T  = 20,
	parameter int ERASE_T = 300,
	parameter int LOAD_T  = 1500
) (
	input  wire logic        clk,
	input  wire logic        fail_en,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] din,
	output logic      [15:0] dout,
	output logic             rb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [bit [15:0]];
	logic [15:0] a_lat, pd, rd, smask;
	int          n, busy, win, held;
	bit          prog, ers, susp, fail, tgl, stg;
	initial {rd, smask} = '0;
	// Suspend parks the erase count, so busy and win together say whether an algorithm runs
	assign rb = busy == 0 && win == 0;
	// Released bus shows the inverse, never a stale copy
	assign dout = (!ce_n && !oe_n) ? rd : ~rd;
	always @(negedge we_n) if (!ce_n) a_lat = addr;
	always @(posedge we_n) if (!ce_n) cmd(a_lat, din);
	always @(posedge clk)
		if (win > 0)
		begin
			win--;
			if (win == 0) busy = ERASE_T;
		end
		else if (busy > 0)
		begin
			busy--;
			if (busy == 0 && prog) prog = 1'b0;
			else if (busy == 0)
			begin
				foreach (mem[k]) if (ers && smask[k[15:12]]) mem[k] = 16'hffff;
				ers = 1'b0;
			end
		end
	// Ce_n may fall in the same step as oe_n; look once both have settled
	always @(negedge oe_n)
		#1 if (!ce_n && busy != 0)
		begin
			tgl = !tgl;
			stg = stg ^ ers;
			rd = {8'h00, prog ? ~pd[7] : 1'b0, tgl, fail, 1'b0, ers, stg, 2'b00};
		end
		else if (!ce_n && win > 0)
		begin
			tgl = !tgl;
			rd = {9'h000, tgl, 6'h00};
		end
		else if (!ce_n) rd = mem.exists(addr) ? mem[addr] : 16'hffff;
	task automatic cmd(input logic [15:0] a, input logic [15:0] d);
		if (d[7:0] == 8'hf0 && n != 6) {busy, win, n, prog, ers, susp, fail} = '0;
		else if (win > 0 && d[7:0] == 8'h30) {smask[a[15:12]], win} = {1'b1, LOAD_T};
		else if (ers && !susp && d[7:0] == 8'hb0)
		begin
			// Park the erase so a program during suspend can own the timer
			held = win > 0 ? ERASE_T : busy;
			{busy, win, susp} = {64'h0, 1'b1};
		end
		else if (susp && d[7:0] == 8'h30) {busy, susp} = {held, 1'b0};
		else if (win > 0) {ers, win, smask} = '0;
		else if (n == 6) {mem[a], pd, prog, fail, busy, n} = {d, d, 1'b1, fail_en,
			fail_en ? -32'sd1 : PROG_T, 32'h0};
		else if (n == 5)
		begin
			n = 0;
			if (d[7:0] == 8'h10) {ers, smask, busy} = {1'b1, 16'hffff, ERASE_T};
			if (d[7:0] == 8'h30) {ers, smask, win} = {1'b1, 16'h1 << a[15:12], LOAD_T};
		end
		else if (n == 2) n = a[10:0] != 11'h555 ? 0 : d[7:0] == 8'h80 ? 3 : d[7:0] == 8'ha0 ? 6 : 0;
		else if (n == 1 || n == 4) n = a[10:0] == 11'h2aa && d[7:0] == 8'h55 ? n + 1 : 0;
		else n = a[10:0] == 11'h555 && d[7:0] == 8'haa ? n + 1 : 0;
	endtask : cmd
endmodule : flash_model

// file: sim/flash_host_bench.sv
// Self-checking bench: Wishbone orders to the host, flash model on the far side.
// Assumes the monitor binds itself to the host.
module flash_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  wb_adr_i = '0;
	logic [31:0] wb_dat_i = '0;
	logic        wb_we_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        fail_en = 1'b0;
	logic [31:0] wb_dat_o, rd;
	logic        wb_ack_o, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n, rb;
	logic [15:0] flash_addr, flash_dq_o, dq_i, dq_bus;
	int          mismatches = 0;
	int          n_checks = 0;
	always #10 sys_clk = ~sys_clk;
	assign dq_bus = !flash_dq_oe_n ? flash_dq_o : dq_i;
	flash_host i_flash_host (.sys_clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
		.wb_sel_i(4'hf), .wb_cyc_i, .wb_stb_i, .wb_ack_o, .flash_ce_n, .flash_oe_n,
		.flash_we_n, .flash_addr, .flash_dq_o, .flash_dq_oe_n, .flash_dq_i(dq_bus),
		.ready_busy_output(rb));
	flash_model i_flash_model (.clk(sys_clk), .fail_en, .ce_n(flash_ce_n), .oe_n(flash_oe_n),
		.we_n(flash_we_n), .addr(flash_addr), .din(dq_bus), .dout(dq_i), .rb);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Waits for ack however long it takes; only the watchdog ends a hang
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		{wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'b11};
		do
		begin
			@(posedge sys_clk);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	// Status polled over the bus; a stuck busy bit ends at the watchdog
	task automatic op(input logic [15:0] a, input logic [15:0] d, input logic [3:0] o);
		wb(flash_host_pkg::REG_ADDR, 1'b1, {16'h0, a});
		wb(flash_host_pkg::REG_DATA, 1'b1, {16'h0, d});
		wb(flash_host_pkg::REG_CTRL, 1'b1, {28'h0, o});
		do
		begin
			wb(flash_host_pkg::REG_STAT, 1'b0, '0);
		end
		while (rd[3] !== 1'b0);
	endtask : op
	task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
		op(a, 16'h0, flash_host_pkg::OP_READ);
		wb(flash_host_pkg::REG_DATA, 1'b0, '0);
		chk(rd & 32'hffff, {16'h0, exp});
	endtask : rdchk
	task automatic finish_test();
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		finish_test();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wb(4'h2, 1'b0, '0);
		chk(rd, 32'h0);
		wb(flash_host_pkg::REG_STAT, 1'b0, '0);
		chk(rd & 32'h9, 32'h1);
		op(16'h1123, 16'h1234, flash_host_pkg::OP_PROGRAM);
		chk(rd & 32'h6, 32'h4);
		rdchk(16'h1123, 16'h1234);
		fail_en <= 1'b1;
		op(16'h1200, 16'h0f0f, flash_host_pkg::OP_PROGRAM);
		chk(rd & 32'h6, 32'h2);
		fail_en <= 1'b0;
		op(16'h0, 16'h0, flash_host_pkg::OP_RESET);
		op(16'h0, 16'h0, flash_host_pkg::OP_CHIP_ERASE);
		chk(rd & 32'hf, 32'h5);
		rdchk(16'h1123, 16'hffff);
		op(16'h1123, 16'h1234, flash_host_pkg::OP_PROGRAM);
		op(16'h2040, 16'h5a5a, flash_host_pkg::OP_PROGRAM);
		op(16'h2000, 16'h0, flash_host_pkg::OP_SECT_ERASE);
		op(16'h3000, 16'h0, flash_host_pkg::OP_SECT_ADD);
		op(16'h0, 16'h0, flash_host_pkg::OP_SUSPEND);
		// The ready pin reaches STAT a few cycles after busy clears
		repeat (5) @(posedge sys_clk);
		wb(flash_host_pkg::REG_STAT, 1'b0, '0);
		chk(rd & 32'h1, 32'h1);
		rdchk(16'h1123, 16'h1234);
		op(16'h1300, 16'h00c3, flash_host_pkg::OP_PROGRAM);
		chk(rd & 32'h6, 32'h4);
		rdchk(16'h1300, 16'h00c3);
		op(16'h2000, 16'h0, flash_host_pkg::OP_RESUME);
		rdchk(16'h2040, 16'hffff);
		rdchk(16'h1123, 16'h1234);
		op(16'h2040, 16'h5a5a, flash_host_pkg::OP_PROGRAM);
		op(16'h2000, 16'h0, flash_host_pkg::OP_SECT_ERASE);
		op(16'h1123, 16'h0, flash_host_pkg::OP_PROGRAM);
		repeat (1600) @(posedge sys_clk);
		rdchk(16'h2040, 16'h5a5a);
		finish_test();
	end
endmodule : flash_host_bench
